// ===== logic/pio_bank.sv
// Twelve byte-wide parallel I/O ports with data latches and direction registers.
`timescale 1ns/1ps

// Operation
// - Direction one enables driver from latch
// - Direction zero disables driver, pin input
// - Port zero/one direction write-only, read meaningless
// - Normal data read returns pin levels
// - Outputs read latch; inputs hide latch
// - Data writes always store into latch
// - Bit set/clear reads return latch
// - Data latch reset patterns for 3,4,6,A,B
// - Direction registers reset implemented bits zero
// - Direction only on 0,1,2,5,7,8,9; rest open-drain except port B low nibble
// - Port B low nibble output-only; port8 pin4 undriven
// - Bit n controls pin n
// - Twelve independently addressed byte ports
// - Reset leaves other latch bits unchanged
// - Standby float forces high impedance, gates input
module pio_bank (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // Register port
  input  wire pio_pkg::pio_bus_t     bus,
  output logic [7:0]                 rdata,
  // Standby control
  input  wire pio_pkg::pio_standby_t standby,
  // Pins: port n occupies bits 8n+7..8n, port A index 10, port B index 11
  input  wire logic [95:0]           pin_in,
  output logic [95:0]                pin_out,
  output logic [95:0]                pin_oe
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]  latch [pio_pkg::NUM_PORTS];
  logic [7:0]  dir   [pio_pkg::NUM_PORTS];
  logic [95:0] pin_meta;
  logic [95:0] pin_sync;
  logic        float_pins;
  logic [7:0]  next_rdata;
  logic [95:0] next_oe;
  logic [95:0] next_out;

  function automatic logic [7:0] port_ofs(input int p);
    case (p)
      0:       port_ofs = pio_pkg::OFS_PORT0_DATA;
      1:       port_ofs = pio_pkg::OFS_PORT1_DATA;
      2:       port_ofs = pio_pkg::OFS_PORT2_DATA;
      3:       port_ofs = pio_pkg::OFS_PORT3_DATA;
      4:       port_ofs = pio_pkg::OFS_PORT4_DATA;
      5:       port_ofs = pio_pkg::OFS_PORT5_DATA;
      6:       port_ofs = pio_pkg::OFS_PORT6_DATA;
      7:       port_ofs = pio_pkg::OFS_PORT7_DATA;
      8:       port_ofs = pio_pkg::OFS_PORT8_DATA;
      9:       port_ofs = pio_pkg::OFS_PORT9_DATA;
      10:      port_ofs = pio_pkg::OFS_PORTA_DATA;
      default: port_ofs = pio_pkg::OFS_PORTB_DATA;
    endcase
  endfunction : port_ofs

  function automatic logic [7:0] dir_ofs(input int p);
    case (p)
      0:       dir_ofs = pio_pkg::OFS_PORT0_DIRECTION;
      1:       dir_ofs = pio_pkg::OFS_PORT1_DIRECTION;
      2:       dir_ofs = pio_pkg::OFS_PORT2_DIRECTION;
      5:       dir_ofs = pio_pkg::OFS_PORT5_DIRECTION;
      7:       dir_ofs = pio_pkg::OFS_PORT7_DIRECTION;
      8:       dir_ofs = pio_pkg::OFS_PORT8_DIRECTION;
      default: dir_ofs = pio_pkg::OFS_PORT9_DIRECTION;
    endcase
  endfunction : dir_ofs

  function automatic logic [7:0] dir_mask(input int p);
    case (p)
      5:       dir_mask = pio_pkg::DIR_MASK_PORT5;
      8:       dir_mask = pio_pkg::DIR_MASK_PORT8;
      9:       dir_mask = pio_pkg::DIR_MASK_PORT9;
      default: dir_mask = 8'hff;
    endcase
  endfunction : dir_mask

  // ****************************************************************
  // Pin synchronisers and standby float level
  // ****************************************************************
  always_ff @(posedge mclk) begin
    pin_meta <= pin_in;
    pin_sync <= pin_meta;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      float_pins <= 1'b0;
    end else begin
      float_pins <= standby.standby_stop & standby.standby_pin_float_bit;
    end
  end

  // ****************************************************************
  // Per-port latches and direction registers
  // ****************************************************************
  for (genvar p = 0; p < pio_pkg::NUM_PORTS; p++) begin : g_port
    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        // only the documented bits are loaded, the rest keep their value.
        if (p == 3 || p == 6) begin
          latch[p][5:0] <= pio_pkg::RST_DATA_LOW6[5:0];
        end else if (p == 4) begin
          latch[p][3:0] <= pio_pkg::RST_DATA_LOW4[3:0];
        end else if (p == pio_pkg::P_A || p == pio_pkg::P_B) begin
          latch[p] <= pio_pkg::RST_DATA_ALL;
        end
      end else if (bus.wr && bus.addr == port_ofs(p)) begin
        latch[p] <= bus.wdata;
      end
    end

    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        dir[p] <= pio_pkg::RST_DIRECTION;
      end else if (pio_pkg::HAS_DIRECTION[p] && bus.wr && bus.addr == dir_ofs(p)) begin
        dir[p] <= bus.wdata & dir_mask(p);
      end
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  always_comb begin
    next_oe  = '0;
    next_out = '0;
    for (int p = 0; p < pio_pkg::NUM_PORTS; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pio_pkg::HAS_DIRECTION[p]) begin
          next_oe[8*p+b]  = dir[p][b];
          next_out[8*p+b] = latch[p][b];
        end else if (p == pio_pkg::P_B && pio_pkg::PORTB_OUT_ONLY[b]) begin
          // Output-only pins drive their latch level unless the pins are floated.
          next_oe[8*p+b]  = 1'b1;
          next_out[8*p+b] = latch[p][b];
        end else begin
          // Open-drain: pull low on a zero, release on a one.
          next_oe[8*p+b]  = ~latch[p][b];
          next_out[8*p+b] = 1'b0;
        end
      end
    end
    next_oe[64+4] = 1'b0;
    if (float_pins) begin
      next_oe = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pin_oe  <= '0;
      pin_out <= '0;
    end else begin
      pin_oe  <= next_oe;
      pin_out <= next_out;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    next_rdata = pio_pkg::READ_NONE;
    for (int p = 0; p < pio_pkg::NUM_PORTS; p++) begin
      if (bus.addr == port_ofs(p)) begin
        if (bus.latch_rd) begin
          next_rdata = latch[p];
        end else if (pio_pkg::HAS_DIRECTION[p]) begin
          // Outputs read their latch, inputs their pin; float gates the input.
          next_rdata = (dir[p] & latch[p]) | (~dir[p] & pin_sync[8*p +: 8] & {8{~float_pins}});
        end else begin
          next_rdata = pin_sync[8*p +: 8] & {8{~float_pins}};
        end
      end
      if (pio_pkg::HAS_DIRECTION[p] && p > 1 && bus.addr == dir_ofs(p)) begin
        next_rdata = dir[p];
      end
    end
    // port zero and one direction offsets fall through to zero.
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata <= '0;
    end else if (bus.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= '0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_dir_write_takes: assert property (@(posedge mclk) disable iff (!reset_n)
    bus.wr && bus.addr == pio_pkg::OFS_PORT0_DIRECTION |=> dir[0] == $past(bus.wdata))
    else $error("port0 direction not stored");
  a_oe_follows_dir: assert property (@(posedge mclk) disable iff (!reset_n)
    !float_pins |=> pin_oe[7:0] == $past(dir[0]))
    else $error("port0 enable does not follow direction");
  a_dir0_read_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    bus.rd && bus.addr == pio_pkg::OFS_PORT0_DIRECTION |=> rdata == 8'h00)
    else $error("write-only direction read nonzero");
  a_latch_store: assert property (@(posedge mclk) disable iff (!reset_n)
    bus.wr && bus.addr == pio_pkg::OFS_PORT7_DATA |=> latch[7] == $past(bus.wdata))
    else $error("latch write lost");
  a_latch_read: assert property (@(posedge mclk) disable iff (!reset_n)
    bus.rd && bus.latch_rd && bus.addr == pio_pkg::OFS_PORT2_DATA |=> rdata == $past(latch[2]))
    else $error("bit op read not latch");
  a_reset_porta: assert property (@(posedge mclk) $rose(reset_n) |-> latch[pio_pkg::P_A] == 8'hff)
    else $error("port A reset pattern wrong");
  a_reset_dir: assert property (@(posedge mclk) $rose(reset_n) |-> dir[5] == 8'h00)
    else $error("direction not cleared");
  a_p84_no_drive: assert property (@(posedge mclk) disable iff (!reset_n) !pin_oe[68])
    else $error("port8 pin4 driven");
  a_float_hiz: assert property (@(posedge mclk) disable iff (!reset_n) float_pins |=> pin_oe == '0)
    else $error("standby float not honoured");
  a_read_idle: assert property (@(posedge mclk) disable iff (!reset_n) !bus.rd |=> rdata == 8'h00)
    else $error("read data outside answer cycle");
  c_output_drive: cover property (@(posedge mclk) pin_oe[0] && pin_out[0]);
  c_float: cover property (@(posedge mclk) float_pins);
  c_latch_read: cover property (@(posedge mclk) bus.rd && bus.latch_rd);

  // ****************************************************************
  // Further pin and register checks
  // ****************************************************************
  // Open-drain port A pulls low on a zero and never drives a high level.
  a_porta_open_drain: assert property (@(posedge mclk) disable iff (!reset_n)
    !float_pins |=> pin_oe[87:80] == ~$past(latch[pio_pkg::P_A]))
    else $error("port A open-drain enable wrong");
  a_porta_low_level: assert property (@(posedge mclk) disable iff (!reset_n)
    pin_out[87:80] == 8'h00)
    else $error("port A drives a high level");
  // Port B low nibble drives its latch whenever the pins are not floated.
  a_portb_out_only: assert property (@(posedge mclk) disable iff (!reset_n)
    !float_pins |=> pin_oe[91:88] == 4'hf)
    else $error("port B output-only pins not driven");
  a_portb_out_level: assert property (@(posedge mclk) disable iff (!reset_n)
    1'b1 |=> pin_out[91:88] == $past(latch[pio_pkg::P_B][3:0]))
    else $error("port B output-only level wrong");
  // Unimplemented direction bits never hold a one.
  a_dir5_mask: assert property (@(posedge mclk) disable iff (!reset_n)
    !dir[5][7])
    else $error("port5 bit7 direction set");
  a_dir8_mask: assert property (@(posedge mclk) disable iff (!reset_n)
    !dir[8][4])
    else $error("port8 bit4 direction set");
  a_dir9_mask: assert property (@(posedge mclk) disable iff (!reset_n)
    dir[9][7:3] == 5'h00)
    else $error("port9 upper direction set");
  a_dir1_read_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    bus.rd && bus.addr == pio_pkg::OFS_PORT1_DIRECTION |=> rdata == 8'h00)
    else $error("port1 direction read nonzero");
  a_dir2_readback: assert property (@(posedge mclk) disable iff (!reset_n)
    bus.rd && bus.addr == pio_pkg::OFS_PORT2_DIRECTION |=> rdata == $past(dir[2]))
    else $error("port2 direction read wrong");
  a_reset_portb: assert property (@(posedge mclk) $rose(reset_n) |-> latch[pio_pkg::P_B] == 8'hff)
    else $error("port B reset pattern wrong");
  // A floated input pin reads as zero so an open input cannot leak into software.
  a_float_read_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    float_pins && bus.rd && !bus.latch_rd && bus.addr == pio_pkg::OFS_PORTA_DATA |=> rdata == 8'h00)
    else $error("floated pins not gated on read");
  c_dir_read: cover property (@(posedge mclk) bus.rd && bus.addr == pio_pkg::OFS_PORT2_DIRECTION);
  c_open_drain_low: cover property (@(posedge mclk) pin_oe[80]);

endmodule : pio_bank

// ===== logic/pio_pkg.sv
// Package holding the register map, reset patterns and carriers of the parallel port bank.
package pio_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_PORT0_DATA      = 8'h00;
  localparam logic [7:0] OFS_PORT0_DIRECTION = 8'h01;
  localparam logic [7:0] OFS_PORT1_DATA      = 8'h02;
  localparam logic [7:0] OFS_PORT1_DIRECTION = 8'h03;
  localparam logic [7:0] OFS_PORT2_DATA      = 8'h04;
  localparam logic [7:0] OFS_PORT2_DIRECTION = 8'h06;
  localparam logic [7:0] OFS_PORTA_DATA      = 8'h15;
  localparam logic [7:0] OFS_PORTB_DATA      = 8'h17;
  localparam logic [7:0] OFS_PORT3_DATA      = 8'h20;
  localparam logic [7:0] OFS_PORT4_DATA      = 8'h21;
  localparam logic [7:0] OFS_PORT5_DATA      = 8'h22;
  localparam logic [7:0] OFS_PORT5_DIRECTION = 8'h23;
  localparam logic [7:0] OFS_PORT6_DATA      = 8'h24;
  localparam logic [7:0] OFS_PORT7_DATA      = 8'h25;
  localparam logic [7:0] OFS_PORT7_DIRECTION = 8'h26;
  localparam logic [7:0] OFS_PORT8_DATA      = 8'h27;
  localparam logic [7:0] OFS_PORT8_DIRECTION = 8'h28;
  localparam logic [7:0] OFS_PORT9_DATA      = 8'h29;
  localparam logic [7:0] OFS_PORT9_DIRECTION = 8'h2a;

  // ****************************************************************
  // Port indices, reset values and masks
  // ****************************************************************
  localparam int NUM_PORTS = 12;
  localparam int P_A = 10;
  localparam int P_B = 11;
  localparam logic [7:0] RST_DATA_LOW6   = 8'h3f;
  localparam logic [7:0] RST_DATA_LOW4   = 8'h0f;
  localparam logic [7:0] RST_DATA_ALL    = 8'hff;
  localparam logic [7:0] RST_DIRECTION   = 8'h00;
  localparam logic [7:0] DIR_MASK_PORT5  = 8'h7f;
  localparam logic [7:0] DIR_MASK_PORT8  = 8'hef;
  localparam logic [7:0] DIR_MASK_PORT9  = 8'h07;
  localparam logic [7:0] PORTB_OUT_ONLY  = 8'h0f;
  localparam logic [7:0] PORT8_NO_DRIVE  = 8'h10;
  localparam logic [7:0] READ_NONE       = 8'h00;
  // Ports with a direction register: 0,1,2,5,7,8,9.
  localparam logic [11:0] HAS_DIRECTION  = 12'h3a7;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       latch_rd;
  } pio_bus_t;

  typedef struct packed {
    logic standby_stop;
    logic standby_pin_float_bit;
  } pio_standby_t;

endpackage : pio_pkg

// ===== sim/pio_pin_model.sv
// Pin-side model: resolves each pin from the bank's drive, an external driver and a pull-up.
`timescale 1ns/1ps
module pio_pin_model (
  // Bank side
  input  wire logic [95:0] pin_out,
  input  wire logic [95:0] pin_oe,
  output logic [95:0]      pin_in,
  // External driver
  input  wire logic [95:0] ext_val,
  input  wire logic [95:0] ext_en
);
  // The bank wins where it drives; a pin nobody drives floats high through its pull-up.
  always_comb begin
    for (int i = 0; i < 96; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule : pio_pin_model

// ===== sim/tb_pio_bank.sv
// Self-checking bench for the parallel port bank.
`timescale 1ns/1ps
module tb_pio_bank;
  logic                  mclk;
  logic                  reset_n;
  pio_pkg::pio_bus_t     bus;
  logic [7:0]            rdata;
  pio_pkg::pio_standby_t standby;
  logic [95:0]           pin_in;
  logic [95:0]           pin_out;
  logic [95:0]           pin_oe;
  logic [95:0]           ext_val;
  logic [95:0]           ext_en;
  logic [7:0]            v;
  int                    num_errors;
  int                    num_checks;
  logic [7:0]            ra [5] = '{8'h20, 8'h21, 8'h24, 8'h15, 8'h17};
  logic [7:0]            rm [5] = '{8'h3f, 8'h0f, 8'h3f, 8'hff, 8'hff};
  logic [7:0]            da [3] = '{8'h23, 8'h28, 8'h2a};
  logic [7:0]            dm [3] = '{pio_pkg::DIR_MASK_PORT5, pio_pkg::DIR_MASK_PORT8, pio_pkg::DIR_MASK_PORT9};

  pio_bank dut (.mclk(mclk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .standby(standby),
                .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  pio_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .ext_val(ext_val), .ext_en(ext_en));

  // ****************************************************************
  // Bus tasks and comparison
  // ****************************************************************
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= {a, d, 3'h4};
    @(posedge mclk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic lr, output logic [7:0] d);
    @(posedge mclk);
    bus <= {a, 8'h00, 2'h1, lr};
    @(posedge mclk);
    bus <= '0;
    @(negedge mclk);
    d = rdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic lr, input logic [7:0] exp);
    rd(a, lr, v);
    chk(v, exp);
  endtask : rdchk

  // Pin outputs follow a write two edges later; four cycles leave margin.
  task automatic settle;
    repeat (4) @(negedge mclk);
  endtask : settle

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    stop_test();
  end

  initial begin
    reset_n = 1'b0;
    bus = '0;
    standby = '0;
    ext_val = 96'h99 << 16;
    ext_en = 96'hff << 16;
    num_errors = 0;
    num_checks = 0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    settle();
    chk(pin_oe[23:0], 24'h0);
    chk(pin_oe[79:56], 24'h0);
    chk(pin_oe[47:40], 8'h00);
    chk(pin_oe[95:80], 16'h0f00);
    chk(pin_out[95:80], 16'h0f00);
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], 1'b1, v);
      chk(v & rm[i], rm[i]);
    end
    // Data loaded before the direction is opened.
    wr(8'h00, 8'ha5);
    settle();
    chk(pin_oe[7:0], 8'h00);
    wr(8'h01, 8'hff);
    wr(8'h03, 8'hff);
    settle();
    chk(pin_oe[15:0], 16'hffff);
    chk(pin_out[7:0], 8'ha5);
    rdchk(8'h00, 1'b0, 8'ha5);
    rdchk(8'h01, 1'b0, pio_pkg::READ_NONE);
    rdchk(8'h03, 1'b0, pio_pkg::READ_NONE);
    // Port 2 mixes outputs on the low nibble with driven inputs above.
    wr(8'h06, 8'h0f);
    wr(8'h04, 8'h3c);
    settle();
    chk(pin_oe[23:16], 8'h0f);
    chk(pin_out[19:16], 4'hc);
    rdchk(8'h04, 1'b0, 8'h9c);
    rdchk(8'h04, 1'b1, 8'h3c);
    rdchk(8'h06, 1'b0, 8'h0f);
    for (int i = 0; i < 3; i++) begin
      wr(da[i], 8'hff);
      rdchk(da[i], 1'b0, dm[i]);
    end
    settle();
    chk(pin_oe[68], 1'b0);
    chk(pin_oe[79:72], 8'h07);
    chk(pin_oe[47:40], 8'h7f);
    wr(8'h17, 8'h5a);
    wr(8'h15, 8'h3c);
    settle();
    chk(pin_oe[95:80], 16'hafc3);
    chk(pin_out[95:80], 16'h0a00);
    rdchk(8'h15, 1'b0, 8'h3c);
    wr(8'h05, 8'hff);
    rdchk(8'h05, 1'b0, 8'h00);
    standby <= 2'h3;
    settle();
    chk(pin_oe, 96'h0);
    rdchk(8'h15, 1'b0, 8'h00);
    standby <= 2'h0;
    settle();
    chk(pin_oe[15:0], 16'hffff);
    stop_test();
  end
endmodule : tb_pio_bank
